//--- logic/debug_link_pkg.sv
// package: constants and carriers for the debug serial link
package debug_link_pkg;
   // ----------------------------------------
   // timing and counts
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CAL_LOW_BITS    = 8;
   localparam int unsigned MIN_RATE_DIV    = 512;
   localparam int unsigned CNT_W           = 13;
   localparam logic [CNT_W-1:0] CAL_MAX    = 13'h1000;
   localparam logic [CNT_W-1:0] CAL_MIN    = 13'h0020;
   localparam logic [3:0] BREAK_BITS       = 4'h9;
   localparam logic [3:0] FRAME_BITS       = 4'hA;
   localparam logic [16:0] SIZE_ZERO_LEN   = 17'h1_0000;
   // ----------------------------------------
   // commands
   // ----------------------------------------
   localparam logic [7:0] CMD_WR_PROG = 8'h0A;
   localparam logic [7:0] CMD_RD_PROG = 8'h0B;
   localparam logic [7:0] CMD_WR_DATA = 8'h0C;
   localparam logic [7:0] CMD_RD_DATA = 8'h0D;
   localparam logic [7:0] BLOCKED_BYTE = 8'hFF;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        prog;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_req_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  rdata;
   } mem_rsp_s;

   typedef struct packed {
      logic debugHalted;
      logic readProtect;
      logic flashUnlocked;
   } gate_s;
endpackage : debug_link_pkg

//--- logic/serial_bit_engine.sv
// module: character receiver and transmitter sharing one measured bit period
module serial_bit_engine
   import debug_link_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             lineIn,
   input  wire logic [CNT_W-1:0] bitPeriod,
   input  wire logic             rateValid,
   input  wire logic             txStart,
   input  wire logic [7:0]       txByte,
   output logic                  rxValid,
   output logic [7:0]            rxByte,
   output logic                  txBusy,
   output logic                  txLine
);
   typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} rx_e;
   rx_e              rxSt_r, rxSt_nxt;
   logic [CNT_W-1:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
   logic [3:0]       rxBit_r, rxBit_nxt, txBit_r, txBit_nxt;
   logic [7:0]       rxSh_r, rxSh_nxt;
   logic [9:0]       txSh_r, txSh_nxt;
   logic             rxValid_nxt, txBusy_nxt;
   logic             txBusy_r;

   always_comb begin
      rxSt_nxt    = rxSt_r;
      rxCnt_nxt   = rxCnt_r;
      rxBit_nxt   = rxBit_r;
      rxSh_nxt    = rxSh_r;
      rxValid_nxt = 1'b0;
      txCnt_nxt   = txCnt_r;
      txBit_nxt   = txBit_r;
      txSh_nxt    = txSh_r;
      txBusy_nxt  = txBusy_r;
      unique case (rxSt_r)
         RX_IDLE: begin
            // wait one and a half bit periods past the start edge, sample mid first data bit
            if (rateValid && !lineIn && !txBusy_r) begin
               rxSt_nxt  = RX_BITS;
               rxCnt_nxt = bitPeriod + (bitPeriod >> 1);
               rxBit_nxt = 4'h0;
            end
         end
         RX_BITS: begin
            if (rxCnt_r == '0) begin
               rxSh_nxt  = {lineIn, rxSh_r[7:1]};
               rxCnt_nxt = bitPeriod - CNT_W'(1);
               rxBit_nxt = rxBit_r + 4'h1;
               if (rxBit_r == 4'h7) begin
                  rxSt_nxt = RX_STOP;
               end
            end else begin
               rxCnt_nxt = rxCnt_r - CNT_W'(1);
            end
         end
         RX_STOP: begin
            if (rxCnt_r == '0) begin
               rxSt_nxt    = RX_IDLE;
               rxValid_nxt = lineIn;
            end else begin
               rxCnt_nxt = rxCnt_r - CNT_W'(1);
            end
         end
      endcase
      if (!rateValid) begin
         rxSt_nxt = RX_IDLE;
      end
      if (!txBusy_r) begin
         if (txStart && rateValid) begin
            txSh_nxt   = {1'b1, txByte, 1'b0};
            txBusy_nxt = 1'b1;
            txCnt_nxt  = bitPeriod - CNT_W'(1);
            txBit_nxt  = 4'h0;
         end
      end else if (txCnt_r == '0) begin
         txSh_nxt  = {1'b1, txSh_r[9:1]};
         txCnt_nxt = bitPeriod - CNT_W'(1);
         txBit_nxt = txBit_r + 4'h1;
         if (txBit_r == FRAME_BITS - 4'h1) begin
            txBusy_nxt = 1'b0;
         end
      end else begin
         txCnt_nxt = txCnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxSt_r   <= RX_IDLE;
         rxCnt_r  <= '0;
         rxBit_r  <= 4'h0;
         rxSh_r   <= 8'h00;
         rxValid  <= 1'b0;
         txCnt_r  <= '0;
         txBit_r  <= 4'h0;
         txSh_r   <= 10'h3FF;
         txBusy_r <= 1'b0;
      end else begin
         rxSt_r   <= rxSt_nxt;
         rxCnt_r  <= rxCnt_nxt;
         rxBit_r  <= rxBit_nxt;
         rxSh_r   <= rxSh_nxt;
         rxValid  <= rxValid_nxt;
         txCnt_r  <= txCnt_nxt;
         txBit_r  <= txBit_nxt;
         txSh_r   <= txSh_nxt;
         txBusy_r <= txBusy_nxt;
      end
   end

   assign rxByte = rxSh_r;
   assign txBusy = txBusy_r;
   assign txLine = txSh_r[0];
endmodule : serial_bit_engine

//--- logic/on_chip_debug_unit.sv
// module: debug serial front end with auto-baud and memory command framing
// How it works
// - start bit, eight data LSB first, stop
// - idle and silent until line activity
// - time eight low bits, load period
// - system clocked; counter spans clock/512 rate
// - nine low bit times resets rate logic
// - after break, recalibrate from fresh 80H
// - 0AH: opcode, address, size, then data
// - size zero means 65536 bytes
// - program writes need unlocked flash controller
// - writes dropped unless halted and unprotected
// - 0BH returns bytes, FFH when blocked
// - 0CH writes data memory, same header
// - 0DH returns FFH only when not halted
module on_chip_debug_unit
   import debug_link_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              debugSerialPinIn,
   output logic                   debugSerialPinOut,
   output logic                   debugSerialPinOe_n,
   input  wire debug_link_pkg::gate_s    gate,
   input  wire logic              stopMode,
   output debug_link_pkg::mem_req_s      memReq,
   input  wire debug_link_pkg::mem_rsp_s memRsp,
   output logic                   sysResetReq
);
   import debug_link_pkg::*;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic [2:0] pinSync_r;
   logic       line_r, line_nxt;
   always_comb begin
      line_nxt = line_r;
      if (pinSync_r[1] == pinSync_r[2]) begin
         line_nxt = pinSync_r[2];
      end
   end

   // ----------------------------------------
   // auto-baud and break
   // ----------------------------------------
   typedef enum logic [1:0] {AB_WAIT_HIGH, AB_WAIT_LOW, AB_MEASURE, AB_LOCKED} ab_e;
   ab_e              abSt_r, abSt_nxt;
   logic [CNT_W+3:0] lowCnt_r, lowCnt_nxt;
   logic [CNT_W-1:0] period_r, period_nxt;
   logic             breakSeen;
   logic             rateValid;
   assign rateValid = (abSt_r == AB_LOCKED);
   assign breakSeen = rateValid && !line_r &&
                      (lowCnt_r >= ({4'h0, period_r} * 17'(BREAK_BITS)));

   always_comb begin
      abSt_nxt   = abSt_r;
      lowCnt_nxt = line_r ? '0 : lowCnt_r + (CNT_W+4)'(1);
      period_nxt = period_r;
      unique case (abSt_r)
         AB_WAIT_HIGH: if (line_r) abSt_nxt = AB_WAIT_LOW;
         AB_WAIT_LOW:  if (!line_r) abSt_nxt = AB_MEASURE;
         AB_MEASURE: begin
            if (line_r) begin
               // eight low bits in the calibration character
               period_nxt = lowCnt_r[CNT_W+2:3];
               abSt_nxt   = (lowCnt_r[CNT_W+2:3] >= CAL_MIN[CNT_W-1:0] >> 3) ?
                            AB_LOCKED : AB_WAIT_LOW;
            end else if (lowCnt_r >= {1'b0, CAL_MAX, 3'b000}) begin
               abSt_nxt = AB_WAIT_HIGH;
            end
         end
         AB_LOCKED: if (breakSeen) abSt_nxt = AB_WAIT_HIGH;
      endcase
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   logic       rxValid, txBusy, txLine, txStart_r, txStart_nxt;
   logic [7:0] rxByte, txByte_r, txByte_nxt;
   serial_bit_engine u_engine (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .lineIn    (line_r),
      .bitPeriod (period_r),
      .rateValid (rateValid),
      .txStart   (txStart_r),
      .txByte    (txByte_r),
      .rxValid   (rxValid),
      .rxByte    (rxByte),
      .txBusy    (txBusy),
      .txLine    (txLine)
   );

   // ----------------------------------------
   // command framing
   // ----------------------------------------
   typedef enum logic [2:0] {C_CAL, C_OP, C_HDR, C_WDATA, C_RFETCH, C_RWAIT, C_RSEND} cmd_e;
   cmd_e        cSt_r, cSt_nxt;
   logic [7:0]  op_r, op_nxt;
   logic [1:0]  hdrIdx_r, hdrIdx_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [15:0] size_r, size_nxt;
   logic [16:0] left_r, left_nxt;
   mem_req_s    req_nxt;
   logic        allowWr, allowRd;

   always_comb begin
      allowWr = gate.debugHalted && !gate.readProtect &&
                ((op_r != CMD_WR_PROG) || gate.flashUnlocked);
      allowRd = gate.debugHalted &&
                ((op_r == CMD_RD_DATA) || !gate.readProtect);
   end

   always_comb begin
      cSt_nxt     = cSt_r;
      op_nxt      = op_r;
      hdrIdx_nxt  = hdrIdx_r;
      addr_nxt    = addr_r;
      size_nxt    = size_r;
      left_nxt    = left_r;
      txStart_nxt = 1'b0;
      txByte_nxt  = txByte_r;
      req_nxt     = '0;
      unique case (cSt_r)
         // the 80H itself is consumed by the measurement
         C_CAL: if (rateValid && line_r && !rxValid) cSt_nxt = C_OP;
         C_OP: begin
            if (rxValid) begin
               op_nxt     = rxByte;
               hdrIdx_nxt = 2'd0;
               if (rxByte inside {CMD_WR_PROG, CMD_RD_PROG, CMD_WR_DATA, CMD_RD_DATA}) begin
                  cSt_nxt = C_HDR;
               end
            end
         end
         C_HDR: begin
            if (rxValid) begin
               hdrIdx_nxt = hdrIdx_r + 2'd1;
               unique case (hdrIdx_r)
                  2'd0: addr_nxt[15:8] = rxByte;
                  2'd1: addr_nxt[7:0]  = rxByte;
                  2'd2: size_nxt[15:8] = rxByte;
                  2'd3: begin
                     size_nxt[7:0] = rxByte;
                     left_nxt = ({size_r[15:8], rxByte} == 16'h0000) ?
                                SIZE_ZERO_LEN : {1'b0, size_r[15:8], rxByte};
                     cSt_nxt = (op_r == CMD_WR_PROG || op_r == CMD_WR_DATA) ?
                               C_WDATA : C_RFETCH;
                  end
               endcase
            end
         end
         C_WDATA: begin
            if (rxValid) begin
               req_nxt.req   = allowWr;
               req_nxt.write = 1'b1;
               req_nxt.prog  = (op_r == CMD_WR_PROG);
               req_nxt.addr  = addr_r;
               req_nxt.wdata = rxByte;
               addr_nxt      = addr_r + 16'h0001;
               left_nxt      = left_r - 17'h0_0001;
               if (left_r == 17'h0_0001) cSt_nxt = C_OP;
            end
         end
         C_RFETCH: begin
            if (!txBusy) begin
               if (allowRd) begin
                  req_nxt.req  = 1'b1;
                  req_nxt.prog = (op_r == CMD_RD_PROG);
                  req_nxt.addr = addr_r;
                  cSt_nxt      = C_RWAIT;
               end else begin
                  txByte_nxt  = BLOCKED_BYTE;
                  txStart_nxt = 1'b1;
                  cSt_nxt     = C_RSEND;
               end
            end
         end
         C_RWAIT: begin
            if (memRsp.valid) begin
               txByte_nxt  = memRsp.rdata;
               txStart_nxt = 1'b1;
               cSt_nxt     = C_RSEND;
            end
         end
         C_RSEND: begin
            // wait one cycle for busy to rise, then for the byte to finish
            if (!txStart_r && !txBusy) begin
               addr_nxt = addr_r + 16'h0001;
               left_nxt = left_r - 17'h0_0001;
               cSt_nxt  = (left_r == 17'h0_0001) ? C_OP : C_RFETCH;
            end
         end
      endcase
      if (!rateValid) begin
         cSt_nxt = C_CAL;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSync_r          <= 3'b111;
         line_r             <= 1'b1;
         abSt_r             <= AB_WAIT_HIGH;
         lowCnt_r           <= '0;
         period_r           <= '0;
         cSt_r              <= C_CAL;
         op_r               <= 8'h00;
         hdrIdx_r           <= 2'd0;
         addr_r             <= 16'h0000;
         size_r             <= 16'h0000;
         left_r             <= 17'h0_0000;
         txStart_r          <= 1'b0;
         txByte_r           <= 8'h00;
         memReq             <= '0;
         debugSerialPinOut  <= 1'b1;
         debugSerialPinOe_n <= 1'b1;
         sysResetReq        <= 1'b0;
      end else begin
         pinSync_r          <= {pinSync_r[1:0], debugSerialPinIn};
         line_r             <= line_nxt;
         abSt_r             <= abSt_nxt;
         lowCnt_r           <= lowCnt_nxt;
         period_r           <= period_nxt;
         cSt_r              <= cSt_nxt;
         op_r               <= op_nxt;
         hdrIdx_r           <= hdrIdx_nxt;
         addr_r             <= addr_nxt;
         size_r             <= size_nxt;
         left_r             <= left_nxt;
         txStart_r          <= txStart_nxt;
         txByte_r           <= txByte_nxt;
         memReq             <= req_nxt;
         debugSerialPinOut  <= txLine;
         debugSerialPinOe_n <= !(txBusy || txStart_r);
         sysResetReq        <= stopMode && !line_nxt;
      end
   end
endmodule : on_chip_debug_unit

//--- bench/on_chip_debug_unit_sva.sv
// checker: port-level properties of the debug serial front end
module on_chip_debug_unit_sva
   import debug_link_pkg::*;
(
   input wire logic                     sys_clk,
   input wire logic                     rst_n,
   input wire logic                     debugSerialPinIn,
   input wire logic                     debugSerialPinOut,
   input wire logic                     debugSerialPinOe_n,
   input wire debug_link_pkg::gate_s    gate,
   input wire logic                     stopMode,
   input wire debug_link_pkg::mem_req_s memReq,
   input wire debug_link_pkg::mem_rsp_s memRsp,
   input wire logic                     sysResetReq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_idle_reset;
      $rose(rst_n) |-> debugSerialPinOe_n && debugSerialPinOut && !memReq.req;
   endproperty
   a_idle_reset: assert property (p_idle_reset) else $error("link not idle after reset");
   property p_req_pulse;
      memReq.req |=> !memReq.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("memory request longer than one cycle");
   property p_wr_gate;
      memReq.req && memReq.write |-> gate.debugHalted && !gate.readProtect;
   endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("write issued while halted clear or protected");
   property p_prog_unlock;
      memReq.req && memReq.write && memReq.prog |-> gate.flashUnlocked;
   endproperty
   a_prog_unlock: assert property (p_prog_unlock) else $error("program write while flash locked");
   property p_rd_halt;
      memReq.req && !memReq.write |-> gate.debugHalted;
   endproperty
   a_rd_halt: assert property (p_rd_halt) else $error("read issued while not halted");
   property p_rd_prot;
      memReq.req && !memReq.write && memReq.prog |-> !gate.readProtect;
   endproperty
   a_rd_prot: assert property (p_rd_prot) else $error("program read while protected");
   property p_rsp_start;
      memRsp.valid |-> ##[1:8] !debugSerialPinOe_n;
   endproperty
   a_rsp_start: assert property (p_rsp_start) else $error("no response drive after read data");
   property p_frame_hold;
      $fell(debugSerialPinOe_n) |-> !debugSerialPinOe_n [*8];
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("response drive dropped early");
   property p_sysrst;
      $rose(sysResetReq) |-> $past(stopMode);
   endproperty
   a_sysrst: assert property (p_sysrst) else $error("system reset request outside stop mode");
endmodule : on_chip_debug_unit_sva

bind on_chip_debug_unit on_chip_debug_unit_sva chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .debugSerialPinIn(debugSerialPinIn),
   .debugSerialPinOut(debugSerialPinOut), .debugSerialPinOe_n(debugSerialPinOe_n), .gate(gate),
   .stopMode(stopMode), .memReq(memReq), .memRsp(memRsp), .sysResetReq(sysResetReq));

//--- bench/dbg_host_model.sv
// partner: debug host adapter on the shared serial line
module dbg_host_model (
   input  wire logic sys_clk,
   input  wire logic lineLevel,
   output logic      hostOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock cycles per bit; kept at 8 or more for margin against noise
   int bitCycles = 16;
   initial hostOut = 1'b1;

   task automatic sendBit(input logic b);
      hostOut <= b;
      repeat (bitCycles) @(posedge sys_clk);
   endtask : sendBit
   task automatic sendByte(input logic [7:0] b);
      sendBit(1'b0);
      for (int i = 0; i < 8; i++) sendBit(b[i]);
      sendBit(1'b1);
   endtask : sendByte
   task automatic calibrate();
      sendByte(8'h80);
   endtask : calibrate
   task automatic sendBreak();
      repeat (12) sendBit(1'b0);
      repeat (4) sendBit(1'b1);
   endtask : sendBreak
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] s);
      sendByte(op);
      sendByte(a[15:8]);
      sendByte(a[7:0]);
      sendByte(s[15:8]);
      sendByte(s[7:0]);
   endtask : cmd
   // line stays released (pulled up) while the device answers
   task automatic recvByte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (lineLevel !== 1'b0 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (bitCycles / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bitCycles) @(posedge sys_clk);
         b[i] = lineLevel;
      end
      repeat (bitCycles) @(posedge sys_clk);
      ok = (n < 3000) && (lineLevel === 1'b1);
   endtask : recvByte
endmodule : dbg_host_model

//--- bench/on_chip_debug_unit_tb_top.sv
// testbench: debug serial front end driven by a host model
module on_chip_debug_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import debug_link_pkg::*;
   logic     sys_clk = 1'b0;
   logic     rst_n = 1'b0;
   logic     stopMode = 1'b0;
   gate_s    gate = '0;
   mem_req_s memReq;
   mem_rsp_s memRsp = '0;
   logic     pinOut, pinOe_n, sysResetReq, hostOut, lineLevel, rdPend = 1'b0;
   logic [7:0] rdAddr = 8'h00;
   int       err_total = 0;
   int       tests_run = 0;
   int       cycles = 0;
   mem_req_s seen[$];

   always #5 sys_clk = ~sys_clk;
   assign lineLevel = pinOe_n ? hostOut : pinOut;

   on_chip_debug_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .debugSerialPinIn(lineLevel),
      .debugSerialPinOut(pinOut), .debugSerialPinOe_n(pinOe_n), .gate(gate), .stopMode(stopMode),
      .memReq(memReq), .memRsp(memRsp), .sysResetReq(sysResetReq));
   dbg_host_model host (.sys_clk(sys_clk), .lineLevel(lineLevel), .hostOut(hostOut));

   // ----------------------------------------
   // memory stand-in: read data is address low byte xor 5AH
   // ----------------------------------------
   always @(posedge sys_clk) begin
      rdPend <= memReq.req === 1'b1 && memReq.write === 1'b0;
      rdAddr <= memReq.addr[7:0];
      memRsp <= '{valid: rdPend, rdata: rdAddr ^ 8'h5A};
      if (memReq.req === 1'b1) seen.push_back(memReq);
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic t_idle();
      int bad;
      bad = 0;
      repeat (300) begin
         @(posedge sys_clk);
         if (pinOe_n !== 1'b1 || memReq.req !== 1'b0) bad++;
      end
      check("idle", 32'h0, 32'(bad));
      $display("test idle done");
   endtask : t_idle
   task automatic t_write(input logic [7:0] op, input gate_s g, input int expN);
      gate <= g;
      seen.delete();
      host.cmd(op, 16'h0120, 16'h0002);
      host.sendByte(8'hA5);
      host.sendByte(8'h5A);
      repeat (40) @(posedge sys_clk);
      check("write count", 32'(expN), 32'(seen.size()));
      for (int i = 0; i < seen.size(); i++)
         check("write req", 32'({2'b11, op == CMD_WR_PROG, 16'h0120 + 16'(i), i == 0 ? 8'hA5 : 8'h5A}),
            32'(seen[i]));
   endtask : t_write
   task automatic t_writes();
      t_write(CMD_WR_DATA, '{1'b1, 1'b0, 1'b0}, 2);
      t_write(CMD_WR_DATA, '{1'b1, 1'b1, 1'b1}, 0);
      t_write(CMD_WR_DATA, '{1'b0, 1'b0, 1'b1}, 0);
      t_write(CMD_WR_PROG, '{1'b1, 1'b0, 1'b0}, 0);
      t_write(CMD_WR_PROG, '{1'b1, 1'b0, 1'b1}, 2);
      $display("test writes done");
   endtask : t_writes
   task automatic t_read(input logic [7:0] op, input gate_s g, input logic blocked);
      logic [7:0] b;
      logic       ok;
      gate <= g;
      host.cmd(op, 16'h0130, 16'h0002);
      for (int i = 0; i < 2; i++) begin
         host.recvByte(b, ok);
         check("read byte", blocked ? 32'h0000_00FF : 32'((8'h30 + 8'(i)) ^ 8'h5A), 32'(b));
         check("read stop", 32'h1, 32'(ok));
      end
      // the device still drives the last stop bit; sending now would clip the next start bit
      repeat (host.bitCycles) @(posedge sys_clk);
   endtask : t_read
   task automatic t_reads();
      t_read(CMD_RD_DATA, '{1'b1, 1'b1, 1'b0}, 1'b0);
      t_read(CMD_RD_DATA, '{1'b0, 1'b0, 1'b0}, 1'b1);
      t_read(CMD_RD_PROG, '{1'b1, 1'b0, 1'b0}, 1'b0);
      t_read(CMD_RD_PROG, '{1'b1, 1'b1, 1'b0}, 1'b1);
      t_read(CMD_RD_PROG, '{1'b0, 1'b0, 1'b0}, 1'b1);
      $display("test reads done");
   endtask : t_reads
   // a slower rate after the break only works if the period was measured again
   task automatic t_break();
      host.sendBreak();
      check("no reset req", 32'h0, 32'(sysResetReq));
      host.bitCycles = 32;
      host.calibrate();
      t_write(CMD_WR_DATA, '{1'b1, 1'b0, 1'b0}, 2);
      $display("test break done");
   endtask : t_break
   task automatic t_stop_reset();
      stopMode <= 1'b1;
      host.sendBit(1'b0);
      check("stop reset req", 32'h1, 32'(sysResetReq));
      host.sendBit(1'b1);
      stopMode <= 1'b0;
      host.sendBit(1'b1);
      check("stop reset clear", 32'h0, 32'(sysResetReq));
      $display("test stop reset done");
   endtask : t_stop_reset

   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_idle();
      host.calibrate();
      t_writes();
      t_reads();
      t_break();
      t_stop_reset();
      end_of_test();
   end
endmodule : on_chip_debug_unit_tb_top
